// ===== shared/asf_pkg.sv
/*
  Constants, types and register map of the acceleration sample buffer.
  Assumes one core clock domain (sample source) and one link clock domain
  (serial register interface oversampling clock).
*/
package asf_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_STATUS = 8'h0a;
  localparam logic [7:0] REG_COUNT  = 8'h0d;
  localparam logic [7:0] REG_MODE   = 8'h14;
  localparam logic [7:0] REG_AXIS   = 8'h15;
  localparam logic [7:0] REG_EN     = 8'h17;
  localparam logic [7:0] REG_ROUTE  = 8'h1a;
  localparam logic [7:0] REG_PORT   = 8'hff;
  localparam logic [7:0] ADDR_STEP  = 8'h01;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h20;
  localparam logic [1:0] AXIS_RESET = 2'h0;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Field positions
  localparam int BIT_OVR = 2;
  localparam int BIT_WM  = 1;
  localparam int EN_OVR  = 6;
  localparam int EN_WM   = 5;
  // Depths and event thresholds
  localparam logic [6:0] DEPTH       = 7'h40;
  localparam logic [6:0] BYP_DEPTH   = 7'h01;
  localparam logic [6:0] ROLL_FULL   = 7'h3f;
  localparam logic [6:0] CNT_ZERO    = 7'h00;
  localparam logic [5:0] PTR_STEP    = 6'h01;
  localparam logic [2:0] LAST_ALL    = 3'h5;
  localparam logic [2:0] LAST_ONE    = 3'h1;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  // Serial slave address, value arbitrary
  localparam logic [6:0] DEV_ADDR    = 7'h2a;
  // Idle level of {sample toggle, trigger toggle, scl, sda}
  localparam logic [3:0] SYNC_IDLE   = 4'h3;
  // Host gap after a partial sample read
  localparam int PARTIAL_GAP_NS  = 1500;
  localparam int CORE_PERIOD_NS  = 40;
  localparam int PARTIAL_GAP_CYC = (PARTIAL_GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  typedef enum logic [1:0] {
    ASF_BYPASS       = 2'h0,
    ASF_FILL_ONCE    = 2'h1,
    ASF_ROLLING_MODE = 2'h2,
    ASF_TRIGGER      = 2'h3
  } asf_mode_e;

  typedef enum logic [1:0] {
    ASF_AXIS_ALL = 2'h0,
    ASF_AXIS_X   = 2'h1,
    ASF_AXIS_Y   = 2'h2,
    ASF_AXIS_Z   = 2'h3
  } asf_axis_e;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_DEV   = 9'h002,
    ST_DACK  = 9'h004,
    ST_REG   = 9'h008,
    ST_RACK  = 9'h010,
    ST_WR    = 9'h020,
    ST_WACK  = 9'h040,
    ST_RD    = 9'h080,
    ST_RDACK = 9'h100
  } asf_link_state_e;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } asf_sample_s;
endpackage

// ===== design/asf_accel_sample_fifo.sv
/*
  Acceleration sample buffer with serial register slave.
  Assumes samples arrive on the core clock far slower than the link clock,
  so the held sample is stable while its toggle crosses; scl/sda are pins.
*/
// Contract
// - Buffer holds up to 64 samples of three 16-bit axis words.
// - Bypass acts as a rolling buffer of depth one.
// - Fill-once stores until 64 held, then drops new samples.
// - Rolling mode discards the oldest sample when full.
// - Trigger mode keeps latest 64; on trigger keep newest n, then fill-once.
// - Further triggers ignored until bypass then trigger mode selected.
// - Mode field 00 bypass, 01 fill-once, 10 rolling, 11 trigger; reads back.
// - Write to buffer_mode_and_threshold or 0x15 empties buffer and clears both flags.
// - Data read at buffer_read_port; address counter stops at buffer_read_port in bursts.
// - Stored values equal the processed output register values.
// - Axis field 00 all, 01 x, 10 y, 11 z.
// - Depth in samples is the same for any axis selection.
// - Partially read sample is discarded; next read starts at next sample.
// - Reads beyond the fill level return zero.
// - Fill count at 0x0d shows samples held.
// - Overrun flag set on arrival when full; cleared only by config write.
// - Full and watermark events work in every mode.
// - Watermark flag on reaching count; enable buffer_event_enable, route buffer_event_pin_route, status.
// - Full event after 64 fill-once, 63 rolling, 1 bypass samples.
// - Full event reaches pin only with enable and route bits set.
module asf_accel_sample_fifo (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_sample_valid,
  input  wire asf_pkg::asf_sample_s i_sample,
  input  wire logic                 i_trigger,
  input  wire logic                 i_link_clk,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda_in,
  output wire logic                 o_sda_out,
  output wire logic                 o_sda_oe_n,
  output wire logic                 o_interrupt_pin
);
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // Core domain: hold sample and flip toggles
  logic                 samp_tgl_reg;
  logic                 trig_tgl_reg;
  asf_pkg::asf_sample_s hold_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      samp_tgl_reg <= 1'b0;
      trig_tgl_reg <= 1'b0;
      hold_reg     <= '0;
    end else begin
      if (i_sample_valid) begin
        samp_tgl_reg <= ~samp_tgl_reg;
        hold_reg     <= i_sample;
      end
      if (i_trigger) begin
        trig_tgl_reg <= ~trig_tgl_reg;
      end
    end
  end

  // Link domain synchronisers
  logic       rst_s1_reg;
  logic       link_rst;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] syncq_reg;

  always_ff @(posedge i_link_clk) begin
    rst_s1_reg <= i_reset;
    link_rst   <= rst_s1_reg;
    sync1_reg  <= {samp_tgl_reg, trig_tgl_reg, i_scl, i_sda_in};
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      sync2_reg <= asf_pkg::SYNC_IDLE;
      syncq_reg <= asf_pkg::SYNC_IDLE;
    end else begin
      sync2_reg <= sync1_reg;
      syncq_reg <= sync2_reg;
    end
  end

  wire logic samp_evt  = sync2_reg[3] ^ syncq_reg[3];
  wire logic trig_evt  = sync2_reg[2] ^ syncq_reg[2];
  wire logic scl_rise  = sync2_reg[1] & ~syncq_reg[1];
  wire logic scl_fall  = ~sync2_reg[1] & syncq_reg[1];
  wire logic scl_high  = sync2_reg[1] & syncq_reg[1];
  wire logic start_c   = scl_high & syncq_reg[0] & ~sync2_reg[0];
  wire logic stop_c    = scl_high & ~syncq_reg[0] & sync2_reg[0];
  wire logic sda_bit   = sync2_reg[0];

  // Link registers
  asf_pkg::asf_link_state_e st_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  bc_reg;
  logic        rw_reg;
  logic [7:0]  tx_reg;
  logic        oe_n_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  mode_reg;
  logic [1:0]  axis_reg;
  logic [7:0]  en_reg;
  logic [7:0]  route_reg;
  logic        ovr_reg;
  logic        wm_reg;
  logic        trig_done_reg;
  logic        irq_reg;
  logic [5:0]  wr_ptr_reg;
  logic [5:0]  rd_ptr_reg;
  logic [6:0]  count_reg;
  logic [2:0]  rd_byte_reg;
  asf_pkg::asf_sample_s mem [64];

  wire logic byte_done = bc_reg == asf_pkg::BYTE_BITS;
  wire logic wr_ev     = (st_reg == asf_pkg::ST_WR) & scl_fall & byte_done;
  wire logic reg_ev    = (st_reg == asf_pkg::ST_REG) & scl_fall & byte_done;
  wire logic byte_ld   = scl_fall & (((st_reg == asf_pkg::ST_DACK) & rw_reg) |
                                     ((st_reg == asf_pkg::ST_RDACK) & ~sh_reg[0]));
  wire logic cfg_wr    = wr_ev & ((ptr_reg == asf_pkg::REG_MODE) |
                                  (ptr_reg == asf_pkg::REG_AXIS));

  wire asf_pkg::asf_mode_e mode = asf_pkg::asf_mode_e'(mode_reg[7:6]);
  wire logic [6:0] wm_n = {1'b0, mode_reg[5:0]};
  wire logic is_byp  = mode == asf_pkg::ASF_BYPASS;
  wire logic rolling = is_byp | (mode == asf_pkg::ASF_ROLLING_MODE) |
                       ((mode == asf_pkg::ASF_TRIGGER) & ~trig_done_reg);
  wire logic [6:0] cap = is_byp ? asf_pkg::BYP_DEPTH : asf_pkg::DEPTH;
  wire logic full = count_reg >= cap;
  wire logic [6:0] full_thr = is_byp ? asf_pkg::BYP_DEPTH :
                              (mode == asf_pkg::ASF_ROLLING_MODE) ? asf_pkg::ROLL_FULL :
                              asf_pkg::DEPTH;

  wire logic trig_take = trig_evt & (mode == asf_pkg::ASF_TRIGGER) & ~trig_done_reg;
  wire logic act       = ~cfg_wr & ~trig_take;

  wire asf_pkg::asf_axis_e axis = asf_pkg::asf_axis_e'(axis_reg);
  wire logic all_ax = axis == asf_pkg::ASF_AXIS_ALL;
  wire logic [2:0] last_idx = all_ax ? asf_pkg::LAST_ALL : asf_pkg::LAST_ONE;
  wire logic [1:0] ax_idx = all_ax ? rd_byte_reg[2:1] : axis_reg - 2'h1;
  wire logic last_byte = rd_byte_reg == last_idx;

  wire logic has_data = count_reg != asf_pkg::CNT_ZERO;
  wire logic port_rd  = byte_ld & (ptr_reg == asf_pkg::REG_PORT) & has_data;
  // Partial sample discarded at stop or restart
  wire logic partial  = (start_c | stop_c) & (rd_byte_reg != 3'h0) & has_data;
  wire logic pop      = act & ((port_rd & last_byte) | partial);
  wire logic push     = act & samp_evt & (~full | rolling | pop);
  wire logic drop     = act & samp_evt & full & rolling & ~pop;
  wire logic adv      = pop | drop;
  wire logic [6:0] count_inc = count_reg + {6'h00, push} - {6'h00, adv};
  wire logic trim     = trig_take & (count_reg > wm_n);

  wire logic ovr_set = act & samp_evt & (full | (push & (count_inc == full_thr)));
  wire logic wm_set  = push & (count_inc == wm_n) & (wm_n != asf_pkg::CNT_ZERO);

  // Head word as captured from the data path
  asf_pkg::asf_sample_s head;
  assign head = mem[rd_ptr_reg];
  wire logic [15:0] head_w = (ax_idx == 2'h0) ? head.x : (ax_idx == 2'h1) ? head.y : head.z;
  wire logic [7:0] port_data = has_data ? pick_byte(head_w, rd_byte_reg[0])
                                        : asf_pkg::BYTE_ZERO;
  wire logic [7:0] status_b = (8'(ovr_reg) << asf_pkg::BIT_OVR) |
                              (8'(wm_reg) << asf_pkg::BIT_WM);
  wire logic [7:0] rd_data =
    (ptr_reg == asf_pkg::REG_STATUS) ? status_b :
    (ptr_reg == asf_pkg::REG_COUNT)  ? {1'b0, count_reg} :
    (ptr_reg == asf_pkg::REG_MODE)   ? mode_reg :
    (ptr_reg == asf_pkg::REG_AXIS)   ? {6'h00, axis_reg} :
    (ptr_reg == asf_pkg::REG_EN)     ? en_reg :
    (ptr_reg == asf_pkg::REG_ROUTE)  ? route_reg :
    (ptr_reg == asf_pkg::REG_PORT)   ? port_data : asf_pkg::BYTE_ZERO;

  wire logic [7:0] ptr_next = reg_ev ? sh_reg :
    ((wr_ev | byte_ld) & (ptr_reg != asf_pkg::REG_PORT)) ? ptr_reg + asf_pkg::ADDR_STEP :
    ptr_reg;

  // Serial slave engine
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      st_reg   <= asf_pkg::ST_IDLE;
      sh_reg   <= '0;
      bc_reg   <= '0;
      rw_reg   <= 1'b0;
      tx_reg   <= '0;
      oe_n_reg <= 1'b1;
    end else if (stop_c) begin
      st_reg   <= asf_pkg::ST_IDLE;
      oe_n_reg <= 1'b1;
    end else if (start_c) begin
      st_reg   <= asf_pkg::ST_DEV;
      bc_reg   <= '0;
      oe_n_reg <= 1'b1;
    end else if (scl_rise && st_reg != asf_pkg::ST_IDLE) begin
      sh_reg <= {sh_reg[6:0], sda_bit};
      bc_reg <= bc_reg + 4'h1;
    end else if (scl_fall) begin
      unique case (st_reg)
        asf_pkg::ST_IDLE: begin
        end
        asf_pkg::ST_DEV: if (byte_done) begin
          if (sh_reg[7:1] == asf_pkg::DEV_ADDR) begin
            st_reg   <= asf_pkg::ST_DACK;
            oe_n_reg <= 1'b0;
            rw_reg   <= sh_reg[0];
          end else begin
            st_reg <= asf_pkg::ST_IDLE;
          end
        end
        asf_pkg::ST_DACK, asf_pkg::ST_RDACK: begin
          bc_reg <= '0;
          if (byte_ld) begin
            st_reg   <= asf_pkg::ST_RD;
            oe_n_reg <= rd_data[7];
            tx_reg   <= {rd_data[6:0], 1'b0};
          end else begin
            oe_n_reg <= 1'b1;
            st_reg   <= (st_reg == asf_pkg::ST_DACK) ? asf_pkg::ST_REG : asf_pkg::ST_IDLE;
          end
        end
        asf_pkg::ST_REG: if (byte_done) begin
          st_reg   <= asf_pkg::ST_RACK;
          oe_n_reg <= 1'b0;
        end
        asf_pkg::ST_RACK, asf_pkg::ST_WACK: begin
          st_reg   <= asf_pkg::ST_WR;
          oe_n_reg <= 1'b1;
          bc_reg   <= '0;
        end
        asf_pkg::ST_WR: if (byte_done) begin
          st_reg   <= asf_pkg::ST_WACK;
          oe_n_reg <= 1'b0;
        end
        asf_pkg::ST_RD: begin
          if (byte_done) begin
            st_reg   <= asf_pkg::ST_RDACK;
            oe_n_reg <= 1'b1;
            bc_reg   <= '0;
          end else begin
            oe_n_reg <= tx_reg[7];
            tx_reg   <= {tx_reg[6:0], 1'b0};
          end
        end
        default: st_reg <= asf_pkg::ST_IDLE;
      endcase
    end
  end

  // Register file
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      ptr_reg   <= '0;
      mode_reg  <= asf_pkg::MODE_RESET;
      axis_reg  <= asf_pkg::AXIS_RESET;
      en_reg    <= '0;
      route_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
      if (wr_ev && ptr_reg == asf_pkg::REG_MODE) mode_reg <= sh_reg;
      if (wr_ev && ptr_reg == asf_pkg::REG_AXIS) axis_reg <= sh_reg[1:0];
      if (wr_ev && ptr_reg == asf_pkg::REG_EN) en_reg <= sh_reg;
      if (wr_ev && ptr_reg == asf_pkg::REG_ROUTE) route_reg <= sh_reg;
    end
  end

  // Same storage for any axis selection
  always_ff @(posedge i_link_clk) begin
    if (push) mem[wr_ptr_reg] <= hold_reg;
  end

  // Buffer pointers, count and read byte index
  always_ff @(posedge i_link_clk) begin
    if (link_rst || cfg_wr) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      rd_byte_reg <= '0;
    end else if (trim) begin
      rd_ptr_reg  <= wr_ptr_reg - wm_n[5:0];
      count_reg   <= wm_n;
      rd_byte_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + asf_pkg::PTR_STEP;
      if (adv) rd_ptr_reg <= rd_ptr_reg + asf_pkg::PTR_STEP;
      count_reg <= count_inc;
      if (pop) rd_byte_reg <= '0;
      else if (port_rd) rd_byte_reg <= rd_byte_reg + 3'h1;
    end
  end

  // Flags run in every mode; clear wins over set, since act masks the sets
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      ovr_reg       <= 1'b0;
      wm_reg        <= 1'b0;
      trig_done_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      ovr_reg       <= (ovr_reg & ~cfg_wr) | ovr_set;
      wm_reg        <= (wm_reg & ~cfg_wr) | wm_set;
      trig_done_reg <= (trig_done_reg | trig_take) & ~is_byp;
      // Enable and route gate the pin
      irq_reg <= (ovr_reg & en_reg[asf_pkg::EN_OVR] & route_reg[asf_pkg::BIT_OVR]) |
                 (wm_reg & en_reg[asf_pkg::EN_WM] & route_reg[asf_pkg::BIT_WM]);
    end
  end

  assign o_sda_out       = 1'b0;
  assign o_sda_oe_n      = oe_n_reg;
  assign o_interrupt_pin = irq_reg;

  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (link_rst);

  sequence s_full_arrival;
    samp_evt && full && !pop && act;
  endsequence

  count_max_a: assert property (count_reg <= asf_pkg::DEPTH)
    else $error("fill count above depth");
  bypass_depth_a: assert property (is_byp && !$past(cfg_wr) |-> count_reg <= 7'h01)
    else $error("bypass holds more than one sample");
  fill_drop_a: assert property ((mode == asf_pkg::ASF_FILL_ONCE) ##0 s_full_arrival
    |=> count_reg == $past(count_reg) && wr_ptr_reg == $past(wr_ptr_reg) && ovr_reg)
    else $error("fill-once stored a sample while full");
  roll_drop_a: assert property ((mode == asf_pkg::ASF_ROLLING_MODE) ##0 s_full_arrival
    |=> rd_ptr_reg == $past(rd_ptr_reg) + 6'h01 && count_reg == $past(count_reg))
    else $error("rolling mode did not discard oldest");
  trig_keep_a: assert property (trim |=> count_reg == $past(wm_n) && trig_done_reg)
    else $error("trigger did not keep newest samples");
  cfg_clear_a: assert property (cfg_wr |=> count_reg == 7'h00 && !wm_reg && !ovr_reg)
    else $error("config write did not clear buffer");
  ptr_trap_a: assert property (byte_ld && ptr_reg == asf_pkg::REG_PORT
    |=> ptr_reg == asf_pkg::REG_PORT)
    else $error("address left the data port");
  ovr_sticky_a: assert property (ovr_reg && !cfg_wr |=> ovr_reg)
    else $error("overrun flag lost without config write");
  wm_set_a: assert property (wm_set |=> wm_reg ##1 (o_interrupt_pin ||
    !(en_reg[asf_pkg::EN_WM] && route_reg[asf_pkg::BIT_WM])))
    else $error("watermark flag or pin missing");
  pin_gate_a: assert property (!ovr_reg && !wm_reg ##1 !ovr_reg && !wm_reg
    |=> !o_interrupt_pin)
    else $error("pin raised without a flag");
endmodule

// ===== verif/asf_host_model.sv
/*
  Behavioural two-wire bus master that reaches the buffer registers.
  Assumes an open-drain data line with a pull-up resolved by the bench.
*/
module asf_host_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Five link clocks or more per clock phase
  localparam int HALF = 120;
  localparam int LEAD = 30;
  logic [7:0] rbuf [8];

  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  // Data changes only well inside the low phase
  task automatic put_bit(input logic b);
    #LEAD o_sda_oe_n = b;
    #(HALF - LEAD) o_scl = 1'b1;
    #HALF o_scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    #LEAD o_sda_oe_n = 1'b1;
    #(HALF - LEAD) o_scl = 1'b1;
    #(HALF / 2) b = i_sda;
    #(HALF / 2) o_scl = 1'b0;
  endtask

  task automatic start();
    #LEAD o_sda_oe_n = 1'b1;
    #(HALF - LEAD) o_scl = 1'b1;
    #HALF o_sda_oe_n = 1'b0;
    #HALF o_scl = 1'b0;
  endtask

  task automatic stop();
    #LEAD o_sda_oe_n = 1'b0;
    #(HALF - LEAD) o_scl = 1'b1;
    #HALF o_sda_oe_n = 1'b1;
    #HALF;
  endtask

  task automatic send(input logic [7:0] d);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    send({asf_pkg::DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask

  // Last byte is refused so the slave lets go of the line
  task automatic read_reg(input logic [7:0] a, input int n);
    start();
    send({asf_pkg::DEV_ADDR, 1'b0});
    send(a);
    start();
    send({asf_pkg::DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        get_bit(rbuf[k][i]);
      end
      put_bit(k == n - 1);
    end
    stop();
  endtask
endmodule

// ===== verif/asf_accel_sample_fifo_tb.sv
/*
  Self-checking bench for the acceleration sample buffer.
  Assumes the host model as bus master and a pull-up on the data line.
*/
module asf_accel_sample_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk;
  logic                 lclk;
  logic                 rst;
  logic                 vld;
  logic                 trig;
  asf_pkg::asf_sample_s smp;
  logic                 scl;
  logic                 host_oe_n;
  logic                 sda_out;
  logic                 dut_oe_n;
  logic                 pin;
  wire logic            sda;
  int                   error_cnt;
  int                   samples_checked;
  int                   cyc;

  // Pull-up: low whenever either side pulls
  assign sda = host_oe_n & (dut_oe_n | sda_out);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #6 lclk = ~lclk;
  end

  asf_accel_sample_fifo asf_accel_sample_fifo_inst (
    .i_core_clk     (clk),
    .i_reset        (rst),
    .i_sample_valid (vld),
    .i_sample       (smp),
    .i_trigger      (trig),
    .i_link_clk     (lclk),
    .i_scl          (scl),
    .i_sda_in       (sda),
    .o_sda_out      (sda_out),
    .o_sda_oe_n     (dut_oe_n),
    .o_interrupt_pin(pin)
  );
  asf_host_model host (
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_oe_n(host_oe_n)
  );

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is near 16000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  function automatic asf_pkg::asf_sample_s mk(input int v);
    return {16'h1100 + 16'(v), 16'h2200 + 16'(v), 16'h3300 + 16'(v)};
  endfunction

  task automatic push(input int from, input int n);
    for (int i = from; i < from + n; i++) begin
      @(posedge clk);
      vld <= 1'b1;
      smp <= mk(i);
      @(posedge clk);
      vld <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic pulse_trig();
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] e);
    host.read_reg(a, 1);
    chk8(nm, e, host.rbuf[0]);
  endtask

  // Reads one whole sample at the data port, little end first
  task automatic chk_smp(input int v);
    logic [47:0] e;
    host.read_reg(8'hff, 6);
    e = mk(v);
    e = {e[39:32], e[47:40], e[23:16], e[31:24], e[7:0], e[15:8]};
    for (int k = 0; k < 6; k++) begin
      chk8("sample byte", e[47 - 8 * k -: 8], host.rbuf[k]);
    end
  endtask

  task automatic t_reset();
    rd(8'h14, "mode", asf_pkg::MODE_RESET);
    rd(8'h0d, "count", 8'h00);
    rd(8'h0a, "status", 8'h00);
    rd(8'h15, "axis", 8'h00);
    $display("reset test done");
  endtask

  task automatic t_fill();
    wr(8'h17, 8'h60);
    wr(8'h1a, 8'h06);
    wr(8'h14, 8'h44);
    push(0, 3);
    rd(8'h0a, "status", 8'h00);
    chk8("pin", 8'h00, {7'h00, pin});
    push(3, 1);
    rd(8'h0a, "status", 8'h02);
    chk8("pin", 8'h01, {7'h00, pin});
    push(4, 60);
    rd(8'h0d, "count", 8'h40);
    rd(8'h0a, "status", 8'h06);
    push(64, 2);
    rd(8'h0d, "count", 8'h40);
    rd(8'h14, "mode", 8'h44);
    chk_smp(0);
    rd(8'h0d, "count", 8'h3f);
    wr(8'h17, 8'h00);
    chk8("pin", 8'h00, {7'h00, pin});
    wr(8'h17, 8'h40);
    wr(8'h1a, 8'h04);
    chk8("pin", 8'h01, {7'h00, pin});
    wr(8'h1a, 8'h02);
    chk8("pin", 8'h00, {7'h00, pin});
    $display("fill-once test done");
  endtask

  task automatic t_roll();
    wr(8'h14, 8'h80);
    rd(8'h0d, "count", 8'h00);
    rd(8'h0a, "status", 8'h00);
    push(100, 62);
    rd(8'h0a, "status", 8'h00);
    push(162, 1);
    rd(8'h0a, "status", 8'h04);
    push(163, 7);
    rd(8'h0d, "count", 8'h40);
    chk_smp(106);
    $display("rolling test done");
  endtask

  task automatic t_bypass();
    wr(8'h14, 8'h00);
    push(200, 3);
    rd(8'h0d, "count", 8'h01);
    rd(8'h0a, "status", 8'h04);
    chk_smp(202);
    // No sample arrives during this read, so it stays inside one sample period
    host.read_reg(8'hff, 2);
    chk8("past fill", 8'h00, host.rbuf[0]);
    chk8("past fill", 8'h00, host.rbuf[1]);
    rd(8'h0a, "status", 8'h04);
    $display("bypass test done");
  endtask

  task automatic t_axis();
    asf_pkg::asf_sample_s s;
    wr(8'h14, 8'h40);
    // Single x and single z storage, one sample each
    for (int a = 1; a < 4; a += 2) begin
      wr(8'h15, 8'(a));
      push(700 + a, 1);
      host.read_reg(8'hff, 2);
      s = mk(700 + a);
      chk8("axis lo", (a == 1) ? s.x[7:0] : s.z[7:0], host.rbuf[0]);
      chk8("axis hi", (a == 1) ? s.x[15:8] : s.z[15:8], host.rbuf[1]);
    end
    wr(8'h15, 8'h02);
    rd(8'h15, "axis", 8'h02);
    push(300, 65);
    rd(8'h0d, "count", 8'h40);
    host.read_reg(8'hfe, 5);
    chk8("unmapped", 8'h00, host.rbuf[0]);
    for (int k = 0; k < 2; k++) begin
      s = mk(300 + k);
      chk8("y lo", s.y[7:0], host.rbuf[1 + 2 * k]);
      chk8("y hi", s.y[15:8], host.rbuf[2 + 2 * k]);
    end
    rd(8'h0d, "count", 8'h3e);
    $display("axis test done");
  endtask

  task automatic t_partial();
    wr(8'h15, 8'h00);
    rd(8'h0a, "status", 8'h00);
    push(400, 2);
    host.read_reg(8'hff, 3);
    // Host waits out the realignment gap before the next read
    repeat (asf_pkg::PARTIAL_GAP_CYC) @(posedge clk);
    chk_smp(401);
    rd(8'h0d, "count", 8'h00);
    $display("partial read test done");
  endtask

  task automatic t_trigger();
    wr(8'h14, 8'hc3);
    push(500, 10);
    rd(8'h0d, "count", 8'h0a);
    pulse_trig();
    rd(8'h0d, "count", 8'h03);
    push(510, 2);
    pulse_trig();
    rd(8'h0d, "count", 8'h05);
    rd(8'h0a, "status", 8'h02);
    // Host reads the oldest kept sample, 507, before the mode write to bypass clears the buffer
    chk_smp(507);
    wr(8'h14, 8'h03);
    wr(8'h14, 8'hc3);
    push(600, 4);
    pulse_trig();
    rd(8'h0d, "count", 8'h03);
    $display("trigger test done");
  endtask

  initial begin
    rst = 1'b1;
    vld = 1'b0;
    trig = 1'b0;
    smp = '0;
    cyc = 0;
    error_cnt = 0;
    samples_checked = 0;
    // Two core edges still span several link edges, so the link side sees reset
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_fill();
    t_roll();
    t_bypass();
    t_axis();
    t_partial();
    t_trigger();
    print_verdict();
  end
endmodule
